// [serial_peripheral_model.sv]
// behavioural serial peripheral answering the port across its pins
`timescale 1ns/1ns
module serial_peripheral_model (
  input wire logic sck,
  input wire logic fs,
  input wire logic mosi,
  output logic miso,
  input wire logic pulsed,
  input wire logic cmd,
  input wire logic cpha,
  input wire logic samp_rise,
  input wire logic [4:0] nbits
);
  // ********
  // reply and capture queues
  // ********
  int unsigned miso_q[$];
  int unsigned mosi_q[$];
  logic [15:0] osr = 16'h0000, isr = 16'h0000;
  logic first = 1'h0, act = 1'h0, fs_q = 1'h0;
  int ecnt = 0;
  initial miso = 1'h0;
  // next reply; an empty queue answers zeros
  task automatic load();
    osr = (miso_q.size() > 0) ? 16'(miso_q.pop_front()) : 16'h0000;
    first = 1'h1;
    ecnt = 0;
  endtask : load
  // ********
  // frame and bit handling
  // ********
  // select and command frames open on a falling frame line
  always @(negedge fs) begin
    if (!pulsed) begin
      act = 1'h1;
      load();
      if (!cmd && !cpha) begin
        first = 1'h0;
        miso = osr[nbits - 5'h01];
      end
    end
  end
  // a released line flips, so a late sample shows up
  always @(posedge fs) begin
    if (!pulsed) begin
      act = 1'h0;
      miso = ~miso;
    end
  end
  // capture on one edge, drive on the other
  always @(posedge sck or negedge sck) begin
    if (sck == samp_rise) begin
      if (act) begin
        ecnt++;
        isr = {isr[14:0], mosi};
        if (cmd && ecnt == 8) mosi_q.push_back(32'(isr[7:0]));
        if (!cmd && ecnt == int'(nbits)) begin
          mosi_q.push_back(32'(isr & (16'hffff >> (5'h10 - nbits))));
          if (pulsed) begin
            act = 1'h0;
            miso = ~miso;
          end else if (cpha) load();
        end
      end
      fs_q = fs;
    end else begin
      if (pulsed && fs_q && !act) begin
        act = 1'h1;
        load();
      end
      if (act && (!cmd || ecnt >= 9)) begin // reply after one dead bit
        if (!first) osr = osr << 1;
        first = 1'h0;
        miso = osr[nbits - 5'h01];
      end
    end
  end
endmodule : serial_peripheral_model

// [sync_serial_port.sv]
// synchronous serial port: divider, two fifos, frame engine, interrupt status
// Function
// - first divider stage divides system clock by even prescale 2..254
// - second stage divides by rate field plus one; bit clock is product
// - each data write while ready pushes into an 8 deep 16 bit transmit fifo
// - received words load an 8 deep receive fifo; a read pops oldest
// - master and slave both shift transmit words out on the transmit line
// - four interrupt conditions, enabled ones ORed into one request
// - each interrupt source has its own enable mask bit
// - raw and masked interrupt state both readable
// - word size 4 to 16 bits, most significant bit first, three formats
// - bit clock idles inactive and toggles only during a frame
// - receive timeout raised when bit clock idle and receive fifo holds data
// - select and command formats hold active low frame line whole frame
// - pulsed format: frame pulse one bit before; launch rising, sample falling
// - pulsed format idle: clock and frame low, transmit line released
// - pulsed format: frame pulse, load shifter, MSB out on next rising edge
// - pulsed format: master word enters receive fifo on rising edge after LSB, slave word on the LSB falling edge
// - command format sends 8 bit control first, nothing received meanwhile
// - select format polarity bit sets idle bit clock level
// - select format phase bit picks first or second transition for sampling
// - select format phase zero raises frame line between words
// - select format phase one keeps frame line low between words
// - select format frame line returns high one bit after last capture
`timescale 1ns/1ns
module sync_serial_port (
  input wire logic clk,
  input wire logic rstn,
  input wire logic port_enable,
  input wire logic master_mode,
  input wire logic [1:0] frame_format,
  input wire logic [3:0] word_size_minus_one,
  input wire logic clock_polarity_bit,
  input wire logic clock_phase_bit,
  input wire logic [7:0] clock_prescale_divisor,
  input wire logic [7:0] serial_clock_rate_field,
  input wire logic [3:0] interrupt_mask,
  input wire logic timeout_clear,
  input wire logic overrun_clear,
  input wire logic tx_write,
  input wire logic [15:0] tx_write_data,
  output logic tx_write_ready,
  input wire logic rx_read,
  output logic [15:0] rx_read_data,
  output logic rx_read_valid,
  output logic [3:0] raw_interrupt_status,
  output logic [3:0] masked_interrupt_status,
  output logic interrupt_request,
  output logic serial_bit_clock_out,
  output logic serial_bit_clock_oe,
  input wire logic serial_bit_clock_in,
  output logic frame_select_line_out,
  output logic frame_select_line_oe,
  input wire logic frame_select_line_in,
  output logic serial_transmit_line_out,
  output logic serial_transmit_line_oe,
  input wire logic serial_receive_line
);
  // ********************************************
  // storage
  // ********************************************
  logic [15:0] tx_mem [sync_serial_port_pkg::FIFO_DEPTH];
  logic [15:0] rx_mem [sync_serial_port_pkg::FIFO_DEPTH];
  logic [2:0] tx_wr_ptr, tx_rd_ptr, rx_wr_ptr, rx_rd_ptr;
  logic [3:0] tx_count, rx_count;
  logic [6:0] pre_cnt;
  logic [7:0] rate_cnt;
  logic [6:0] idle_cnt;
  logic [5:0] edge_k;
  logic [15:0] tx_shift, rx_shift;
  logic [3:0] raw_status;
  logic [1:0] capture_dly, push_dly;
  logic sclk_s1, sclk_s2, sclk_s3, fss_s1, fss_s2, rx_s1, rx_s2;
  sync_serial_port_pkg::state_type state;

  // ********************************************
  // decode
  // ********************************************
  wire is_pulsed = frame_format == sync_serial_port_pkg::FMT_PULSED;
  wire is_select = frame_format == sync_serial_port_pkg::FMT_SELECT;
  wire is_command = frame_format == sync_serial_port_pkg::FMT_COMMAND;
  wire running = state == sync_serial_port_pkg::ST_RUN;
  wire idle = state == sync_serial_port_pkg::ST_IDLE;
  // prescale forced even by dropping bit 0; a zero divisor acts as two
  wire [6:0] pre_end = (clock_prescale_divisor[7:1] == 7'h00) ? 7'h00 : clock_prescale_divisor[7:1] - 7'h01;
  wire half_tick = (pre_cnt == pre_end) && (rate_cnt == serial_clock_rate_field);
  wire [4:0] word_bits = {1'b0, word_size_minus_one} + 5'h01;
  wire [4:0] frame_bits = is_command ? word_bits + sync_serial_port_pkg::COMMAND_EXTRA_BITS
                        : (is_pulsed ? word_bits + 5'h01 : word_bits);
  wire [5:0] last_edge = {frame_bits, 1'b0};
  // phase zero captures on odd edges, so its frame ends one half bit sooner
  wire [5:0] end_edge = last_edge + ((is_pulsed || (is_select && !clock_phase_bit)) ? 6'h01 : 6'h02);
  wire [15:0] word_mask = 16'hffff >> (4'hf - word_size_minus_one);
  wire slave_edge = sclk_s2 ^ sclk_s3;
  wire advance = running && (master_mode ? half_tick : slave_edge);
  wire [5:0] next_k = edge_k + 6'h01;
  wire in_edges = next_k <= last_edge;
  wire tx_has = tx_count != 4'h0;
  // select format: phase zero samples odd transitions, phase one even ones
  wire cap_select = clock_phase_bit ? ~next_k[0] : next_k[0];
  wire shift_select = clock_phase_bit ? (next_k[0] && next_k >= 6'h03) : (~next_k[0] && next_k < last_edge);
  // pulsed format samples on falling (even) edges after the frame pulse
  wire cap_pulsed = ~next_k[0] && next_k >= 6'h04;
  wire shift_pulsed = next_k[0] && next_k >= 6'h05;
  // command format receives nothing while the control byte goes out
  wire cap_command = next_k[0] && next_k >= sync_serial_port_pkg::COMMAND_FIRST_CAPTURE_EDGE;
  wire shift_command = ~next_k[0] && next_k <= sync_serial_port_pkg::CONTROL_LAST_SHIFT_EDGE;
  wire capture = advance && in_edges && (is_select ? cap_select : (is_pulsed ? cap_pulsed : cap_command));
  wire shift_out = advance && in_edges && (is_select ? shift_select : (is_pulsed ? shift_pulsed : shift_command));
  wire master_start = port_enable && master_mode && idle && tx_has && half_tick;
  wire slave_start = port_enable && !master_mode && idle
                   && (is_pulsed ? (fss_s2 && slave_edge && sclk_s2) : !fss_s2);
  wire slave_abort = running && !master_mode && !is_pulsed && fss_s2;
  wire frame_end = advance && (master_mode ? next_k == end_edge : next_k == last_edge);
  // phase one may chain words with the frame line held low
  wire chain = frame_end && master_mode && is_select && clock_phase_bit && tx_has;
  wire tx_pop = master_start || (slave_start && tx_has) || chain;
  wire tx_push = tx_write && tx_write_ready;
  // a master reads the receive pin through the synchroniser, so its own capture
  // and push strobes wait the same two clocks; a slave's edges already lag
  wire rx_capture = master_mode ? capture_dly[1] : capture;
  wire rx_push = master_mode ? push_dly[1] : frame_end;
  wire rx_full = rx_count == 4'h8;
  wire rx_pop = rx_read && rx_read_valid;
  wire idle_level = is_select && clock_polarity_bit;

  // ********************************************
  // host side of the fifos
  // ********************************************
  assign tx_write_ready = tx_count != 4'h8;
  assign rx_read_valid = rx_count != 4'h0;
  assign rx_read_data = rx_mem[rx_rd_ptr];
  assign masked_interrupt_status = raw_status & interrupt_mask;
  assign interrupt_request = |masked_interrupt_status;
  assign raw_interrupt_status = raw_status;

  // ********************************************
  // pins
  // ********************************************
  // clock toggles only inside the edge window of a running frame
  assign serial_bit_clock_out = idle_level ^ (running && edge_k <= last_edge && edge_k[0]);
  assign serial_bit_clock_oe = port_enable && master_mode;
  // pulsed format drives high for the two half bits after the first rise
  assign frame_select_line_out = is_pulsed ? (running && (edge_k == 6'h01 || edge_k == 6'h02))
                               : !running;
  assign frame_select_line_oe = port_enable && master_mode;
  assign serial_transmit_line_out = running && (is_command ? (edge_k < 6'h10 && tx_shift[7])
                                  : tx_shift[word_size_minus_one]);
  // pulsed format and slave mode release the line between frames
  assign serial_transmit_line_oe = port_enable && ((is_pulsed || !master_mode) ? running : 1'b1);

  // ********************************************
  // pin synchronisers
  // ********************************************
  always_ff @(posedge clk) begin
    sclk_s1 <= serial_bit_clock_in;
    sclk_s2 <= sclk_s1;
    sclk_s3 <= sclk_s2;
    fss_s1 <= frame_select_line_in;
    fss_s2 <= fss_s1;
    rx_s1 <= serial_receive_line;
    rx_s2 <= rx_s1;
  end

  // ********************************************
  // bit rate divider
  // ********************************************
  // free running so a master frame always starts on a half bit boundary
  always_ff @(posedge clk) begin
    if (!rstn || pre_cnt == pre_end) begin
      pre_cnt <= 7'h00;
    end else begin
      pre_cnt <= pre_cnt + 7'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn || half_tick) begin
      rate_cnt <= 8'h00;
    end else if (pre_cnt == pre_end) begin
      rate_cnt <= rate_cnt + 8'h01;
    end
  end

  // ********************************************
  // transmit fifo
  // ********************************************
  always_ff @(posedge clk) begin
    if (tx_push) begin
      tx_mem[tx_wr_ptr] <= tx_write_data;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      tx_wr_ptr <= 3'h0;
      tx_rd_ptr <= 3'h0;
      tx_count <= sync_serial_port_pkg::COUNT_RESET;
    end else begin
      tx_wr_ptr <= tx_wr_ptr + {2'h0, tx_push};
      tx_rd_ptr <= tx_rd_ptr + {2'h0, tx_pop};
      tx_count <= tx_count + {3'h0, tx_push} - {3'h0, tx_pop};
    end
  end

  // ********************************************
  // receive fifo
  // ********************************************
  // a word arriving into a full fifo is dropped and flagged as overrun
  always_ff @(posedge clk) begin
    if (rx_push && !rx_full) begin
      rx_mem[rx_wr_ptr] <= rx_shift & word_mask;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      rx_wr_ptr <= 3'h0;
      rx_rd_ptr <= 3'h0;
      rx_count <= sync_serial_port_pkg::COUNT_RESET;
    end else begin
      rx_wr_ptr <= rx_wr_ptr + {2'h0, rx_push && !rx_full};
      rx_rd_ptr <= rx_rd_ptr + {2'h0, rx_pop};
      rx_count <= rx_count + {3'h0, rx_push && !rx_full} - {3'h0, rx_pop};
    end
  end

  // ********************************************
  // frame engine
  // ********************************************
  always_ff @(posedge clk) begin
    if (!rstn) begin
      state <= sync_serial_port_pkg::ST_IDLE;
      edge_k <= sync_serial_port_pkg::EDGE_RESET;
    end else begin
      unique case (state)
        sync_serial_port_pkg::ST_IDLE: begin
          if (master_start || slave_start) begin
            state <= sync_serial_port_pkg::ST_RUN;
            edge_k <= (slave_start && is_pulsed) ? 6'h01 : 6'h00;
          end
        end
        sync_serial_port_pkg::ST_RUN: begin
          if (slave_abort) begin
            state <= sync_serial_port_pkg::ST_IDLE;
          end else if (chain) begin
            edge_k <= 6'h00;
          end else if (frame_end) begin
            // phase zero master holds the frame line high for a bit between words
            state <= (master_mode && is_select && !clock_phase_bit)
                   ? sync_serial_port_pkg::ST_GAP : sync_serial_port_pkg::ST_IDLE;
            edge_k <= 6'h00;
          end else if (advance) begin
            edge_k <= next_k;
          end
        end
        sync_serial_port_pkg::ST_GAP: begin
          if (half_tick) begin
            edge_k <= next_k;
            if (edge_k == 6'h01) begin
              state <= sync_serial_port_pkg::ST_IDLE;
            end
          end
        end
        default: begin
          state <= sync_serial_port_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // shifters: load on pop, launch by shifting left, capture into bit 0
  always_ff @(posedge clk) begin
    if (!rstn) begin
      tx_shift <= 16'h0000;
    end else if (tx_pop) begin
      tx_shift <= tx_mem[tx_rd_ptr];
    end else if (slave_start) begin
      tx_shift <= 16'h0000;
    end else if (shift_out) begin
      tx_shift <= {tx_shift[14:0], 1'b0};
    end
  end

  // strobe delay matching the receive pin synchroniser; needed at one clock per half bit
  always_ff @(posedge clk) begin
    capture_dly <= rstn ? {capture_dly[0], capture} : 2'h0;
    push_dly <= rstn ? {push_dly[0], frame_end} : 2'h0;
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      rx_shift <= 16'h0000;
    end else if (rx_capture) begin
      rx_shift <= {rx_shift[14:0], rx_s2};
    end
  end

  // ********************************************
  // interrupt status
  // ********************************************
  // timeout is counted in half bits so it scales with the bit rate
  always_ff @(posedge clk) begin
    if (!rstn || !idle || rx_count == 4'h0) begin
      idle_cnt <= 7'h00;
    end else if (half_tick && idle_cnt != sync_serial_port_pkg::TIMEOUT_HALF_BITS) begin
      idle_cnt <= idle_cnt + 7'h01;
    end
  end

  // sticky bits: a new event in the clearing cycle wins over the clear
  wire [3:0] next_raw = {(rx_push && rx_full) || (raw_status[sync_serial_port_pkg::IRQ_RX_OVERRUN] && !overrun_clear),
                         (idle_cnt == sync_serial_port_pkg::TIMEOUT_HALF_BITS)
                           || (raw_status[sync_serial_port_pkg::IRQ_RX_TIMEOUT] && !timeout_clear),
                         rx_count >= sync_serial_port_pkg::RX_SERVICE_LEVEL,
                         tx_count <= sync_serial_port_pkg::TX_SERVICE_LEVEL};
  always_ff @(posedge clk) begin
    if (!rstn) begin
      raw_status <= sync_serial_port_pkg::STATUS_RESET;
    end else begin
      raw_status <= next_raw;
    end
  end

  // ********************************************
  // checks
  // ********************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence pulse_start_seq;
    running && is_pulsed && master_mode && edge_k == 6'h00 && half_tick;
  endsequence
  sequence pulse_high_seq;
    frame_select_line_out && serial_bit_clock_out;
  endsequence

  AST_PULSE_FRAME: assert property (pulse_start_seq |=> pulse_high_seq)
    else $error("pulsed frame did not open with frame and clock high");
  AST_PULSE_IDLE: assert property (idle && is_pulsed |-> !serial_transmit_line_oe && !frame_select_line_out
    && !serial_bit_clock_out)
    else $error("pulsed format idle lines wrong");
  AST_SELECT_LOW: assert property (running && !is_pulsed |-> !frame_select_line_out)
    else $error("frame line high during select or command frame");
  AST_IDLE_CLOCK: assert property (idle |-> serial_bit_clock_out == idle_level)
    else $error("bit clock not at idle level");
  AST_TX_PUSH: assert property (tx_push && !tx_pop |=> tx_count == $past(tx_count) + 4'h1)
    else $error("transmit push lost");
  AST_RX_POP: assert property (rx_pop && !rx_push |=> rx_count == $past(rx_count) - 4'h1)
    else $error("receive pop lost");
  AST_OVERRUN: assert property (rx_push && rx_full |=> raw_status[sync_serial_port_pkg::IRQ_RX_OVERRUN]
    ##1 (raw_status[sync_serial_port_pkg::IRQ_RX_OVERRUN] || $past(overrun_clear)))
    else $error("overrun not flagged");
  AST_MASK: assert property (interrupt_request |-> |(raw_status & interrupt_mask))
    else $error("request raised by masked source");
  AST_GAP: assert property (frame_end && master_mode && is_select && !clock_phase_bit
    |=> frame_select_line_out [*2])
    else $error("frame line not raised between phase zero words");
  AST_RESET: assert property (@(posedge clk) disable iff (1'b0) $rose(rstn) |-> tx_count == 4'h0
    && rx_count == 4'h0 && raw_status[3:2] == 2'h0 && idle)
    else $error("reset did not clear fifos and status");
endmodule : sync_serial_port

// [sync_serial_port_pkg.sv]
// constants, codes and states shared by the synchronous serial port
package sync_serial_port_pkg;
  // ********************************************
  // frame formats and word layout
  // ********************************************
  localparam logic [1:0] FMT_PULSED = 2'h0;
  localparam logic [1:0] FMT_SELECT = 2'h1;
  localparam logic [1:0] FMT_COMMAND = 2'h2;
  localparam int WORD_WIDTH = 16;
  localparam int FIFO_DEPTH = 8;
  localparam logic [5:0] CONTROL_LAST_SHIFT_EDGE = 6'h0e;
  localparam logic [5:0] COMMAND_FIRST_CAPTURE_EDGE = 6'h13;
  localparam logic [4:0] COMMAND_EXTRA_BITS = 5'h09;
  // ********************************************
  // status bit positions, service levels, reset values
  // ********************************************
  localparam int IRQ_TX_SERVICE = 0;
  localparam int IRQ_RX_SERVICE = 1;
  localparam int IRQ_RX_TIMEOUT = 2;
  localparam int IRQ_RX_OVERRUN = 3;
  localparam logic [3:0] TX_SERVICE_LEVEL = 4'h4;
  localparam logic [3:0] RX_SERVICE_LEVEL = 4'h4;
  localparam logic [6:0] TIMEOUT_HALF_BITS = 7'h40;
  localparam logic [3:0] STATUS_RESET = 4'h0;
  localparam logic [3:0] COUNT_RESET = 4'h0;
  localparam logic [5:0] EDGE_RESET = 6'h00;
  // ********************************************
  // frame engine states
  // ********************************************
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RUN = 3'b010,
    ST_GAP = 3'b100
  } state_type;
endpackage : sync_serial_port_pkg

// [sync_serial_port_tb.sv]
// self-checking bench: queue model of the traffic compared with the port
`timescale 1ns/1ns
module sync_serial_port_tb;
  // ********
  // stimulus, pins and model state
  // ********
  logic clk, rstn, port_enable, master_mode, clock_polarity_bit, clock_phase_bit;
  logic timeout_clear, overrun_clear, tx_write, rx_read, ready, rvalid, irq;
  logic sck, sck_oe, fs, fs_oe, tx, tx_oe;
  logic [1:0] frame_format;
  logic [3:0] word_size_minus_one, interrupt_mask, raw, masked;
  logic [7:0] clock_prescale_divisor, serial_clock_rate_field;
  logic [15:0] tx_write_data, rdata;
  int n_fail = 0, checks_done = 0, nrise = 0, nfall = 0, hi_cnt = 0;
  int unsigned exp_tx[$], exp_rx[$];
  wire logic pulsed = frame_format == sync_serial_port_pkg::FMT_PULSED;
  wire logic cmd = frame_format == sync_serial_port_pkg::FMT_COMMAND;
  wire logic sck_pin = sck_oe ? sck : clock_polarity_bit;
  wire logic fs_pin = fs_oe ? fs : 1'h1;
  wire logic mosi = tx_oe ? tx : ~tx;
  wire logic miso;
  wire logic samp_rise = (pulsed || cmd) ? cmd : ~(clock_polarity_bit ^ clock_phase_bit);
  sync_serial_port i_dut (
    .clk, .rstn, .port_enable, .master_mode, .frame_format, .word_size_minus_one, .clock_polarity_bit,
    .clock_phase_bit, .clock_prescale_divisor, .serial_clock_rate_field, .interrupt_mask, .timeout_clear,
    .overrun_clear, .tx_write, .tx_write_data, .tx_write_ready(ready), .rx_read, .rx_read_data(rdata),
    .rx_read_valid(rvalid), .raw_interrupt_status(raw), .masked_interrupt_status(masked),
    .interrupt_request(irq), .serial_bit_clock_out(sck), .serial_bit_clock_oe(sck_oe),
    .serial_bit_clock_in(sck_pin), .frame_select_line_out(fs), .frame_select_line_oe(fs_oe),
    .frame_select_line_in(fs_pin), .serial_transmit_line_out(tx), .serial_transmit_line_oe(tx_oe),
    .serial_receive_line(miso)
  );
  serial_peripheral_model i_partner (
    .sck(sck_pin), .fs(fs_pin), .mosi, .miso, .pulsed, .cmd, .cpha(clock_phase_bit), .samp_rise,
    .nbits(5'(word_size_minus_one) + 5'h01)
  );
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  // ********
  // checks and transfer tasks
  // ********
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  function automatic int bitclk();
    return int'(clock_prescale_divisor) * (int'(serial_clock_rate_field) + 1);
  endfunction : bitclk
  // pin edge counters; pulse width pins down both divider stages
  always @(posedge sck) nrise++;
  always @(negedge fs) nfall++;
  always @(negedge clk) begin
    if (fs && pulsed) hi_cnt++;
    else if (hi_cnt > 0) begin
      check("frame pulse clocks", bitclk(), hi_cnt);
      hi_cnt = 0;
    end
  end
  task automatic cfg(input logic [1:0] f, input logic p, input logic h);
    @(negedge clk);
    port_enable = 1'h0;
    frame_format = f;
    clock_polarity_bit = p;
    clock_phase_bit = h;
    word_size_minus_one = 4'(3 + $urandom % 13);
    clock_prescale_divisor = 8'(2 + 2 * ($urandom % 3)); // master may run at half the system clock
    serial_clock_rate_field = 8'($urandom % 3);
  endtask : cfg
  task automatic drain();
    while (exp_rx.size() > 0) begin
      check("receive valid", 1, rvalid);
      check("receive word", exp_rx.pop_front(), rdata);
      rx_read = 1'h1;
      @(negedge clk);
      rx_read = 1'h0;
      @(negedge clk);
    end
    check("receive empty", 0, rvalid);
  endtask : drain
  // queue n words, then enable the port and let them run
  task automatic burst(input int n, input bit rd);
    int unsigned w, r;
    int nb, fb;
    nb = int'(word_size_minus_one) + 1;
    fb = nb + (pulsed ? 1 : cmd ? 9 : 0);
    for (int i = 0; i < n; i++) begin
      w = $urandom;
      r = $urandom & (32'hffff >> (16 - nb));
      exp_tx.push_back(cmd ? w & 32'h00ff : w & (32'hffff >> (16 - nb)));
      exp_rx.push_back(r);
      i_partner.miso_q.push_back(r);
      tx_write = 1'h1;
      tx_write_data = w[15:0];
      @(negedge clk);
    end
    tx_write = 1'h0;
    if (n == 8) begin
      check("ready when full", 0, ready);
      tx_write = 1'h1;
      @(negedge clk);
      tx_write = 1'h0;
      @(negedge clk);
      check("transmit service", 0, raw[0]);
    end
    nrise = 0;
    nfall = 0;
    port_enable = 1'h1;
    for (int t = 0; t < 8000 && i_partner.mosi_q.size() < n; t++) @(negedge clk);
    repeat ((fb + 2) * bitclk()) @(negedge clk);
    check("clock rises", n * fb, nrise);
    check("frame falls", (!pulsed && !cmd && clock_phase_bit) ? 1 : n, nfall);
    check("idle clock", (pulsed || cmd) ? 0 : clock_polarity_bit, sck);
    check("idle frame", !pulsed, fs);
    if (pulsed) check("idle transmit drive", 0, tx_oe);
    check("words sent", n, i_partner.mosi_q.size());
    while (i_partner.mosi_q.size() > 0) check("word sent", exp_tx.pop_front(), i_partner.mosi_q.pop_front());
    if (rd) drain();
  endtask : burst
  task automatic sweep(input logic [3:0] er);
    check("raw status", er, raw);
    for (int k = 0; k < 16; k++) begin
      interrupt_mask = 4'(k);
      @(negedge clk);
      check("masked status", er & 4'(k), masked);
      check("request", |(er & 4'(k)), irq);
    end
  endtask : sweep
  task automatic clears();
    timeout_clear = 1'h1;
    overrun_clear = 1'h1;
    @(negedge clk);
    timeout_clear = 1'h0;
    overrun_clear = 1'h0;
    @(negedge clk);
  endtask : clears
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : wrap_up
  // ********
  // main sequence and watchdog
  // ********
  initial begin
    logic [2:0] k;
    {rstn, port_enable, tx_write, rx_read, timeout_clear, overrun_clear} = '0;
    {clock_polarity_bit, clock_phase_bit, interrupt_mask, tx_write_data} = '0;
    master_mode = 1'h1;
    frame_format = sync_serial_port_pkg::FMT_PULSED;
    word_size_minus_one = 4'h7;
    clock_prescale_divisor = 8'h02;
    serial_clock_rate_field = 8'h00;
    void'($urandom(32'h28a8_9fbd));
    repeat (16) @(negedge clk);
    rstn = 1'h1;
    @(negedge clk);
    check("idle after reset", 0, {sck, fs, tx_oe, rvalid});
    sweep(4'h1);
    // pulsed, the four select modes, then command; pulsed first keeps the model's pulse memory clean
    for (int f = 0; f < 6; f++) begin
      k = 3'(f - 1);
      cfg((f == 0) ? 2'h0 : (f == 5) ? 2'h2 : 2'h1, f inside {[1:4]} && k[1], f inside {[1:4]} && k[0]);
      burst(3, 1'h1);
    end
    // fill both fifos, overrun the receive side
    cfg(sync_serial_port_pkg::FMT_PULSED, 1'h0, 1'h0);
    burst(8, 1'h0);
    check("receive service", 1, raw[1]);
    burst(1, 1'h0);
    void'(exp_rx.pop_back()); // word into a full fifo is dropped
    sweep(4'hb);
    drain();
    clears();
    sweep(4'h1);
    // receive timeout with the bit clock idle
    burst(1, 1'h0);
    check("timeout early", 0, raw[2]);
    repeat (32 * bitclk() + 8) @(negedge clk);
    check("timeout raised", 1, raw[2]);
    drain();
    clears();
    check("timeout cleared", 0, raw[2]);
    wrap_up();
  end
  // hang guard, well past the expected run length
  initial begin
    #1_000_000;
    n_fail++;
    wrap_up();
  end
endmodule : sync_serial_port_tb
